// *** usart_regs.vh ***
// Register map, field positions, reset values and timing counts
`ifndef USART_REGS_VH
`define USART_REGS_VH
`define ADDR_TXSC 9'h117
`define ADDR_RXSC 9'h118
`define ADDR_BAUD 9'h119
`define ADDR_RXDATA 9'h11a
`define ADDR_TXDATA 9'h11b
`define TX_MASTER 7
`define TX_NINE 6
`define TX_EN 5
`define TX_SYNC 4
`define TX_POL 3
`define TX_STOP1 2
`define TX_EMPTY 1
`define TX_BIT9 0
`define RX_PORT_EN 7
`define RX_NINE 6
`define RX_SINGLE 5
`define RX_CONT 4
`define RX_IDLE 3
`define RX_FRAMING_ERROR 2
`define RX_OVERRUN_ERROR 1
`define RX_BIT9 0
`define TXSC_RESET 8'h02
`define RXSC_RESET 8'h00
`define BAUD_RESET 8'h00
`define OVERSAMPLE 5'h10
`define HALF_BIT 5'h08
`define SYNC_BIT 5'h04
`define SYNC_HALF 5'h02
`endif

// *** usart_rx_status.v ***
// Serial port status and control registers, baud timer, receiver, sender
//
// What this block does
// - Async stop select: 1 gives one stop bit, 0 gives two.
// - Read-only flag shows 1 when the transmit shift register is empty.
// - Nine-bit send puts the ninth transmit bit after the data byte.
// - Synchronous mode: either receive enable overrides transmit enable.
// - Port enable owns the pins; clearing it holds serial logic in reset.
// - Nine-bit receive select assembles nine data bits, else eight.
// - Single receive works only in synchronous master mode.
// - Continuous receive enables receiver and beats single receive.
// - Idle flag is 1 while idle, 0 from start bit to the stop bit centre.
// - Framing flag belongs to the character just read from the buffer.
// - Overrun sets on overflow, clears when continuous receive is cleared.
// - Ninth received bit is shown for the character just read.
// - Eight-bit free-running baud timer set by the divisor register.
// - Writing the divisor restarts the baud timer at once.
// - Bit rate is clock/16(n+1) async and clock/4(n+1) synchronous master; a sync slave follows the external clock.
// - Two-entry receive buffer; a third character sets overrun, halts.
// - Async start bit checked at half bit, data sampled at bit centres.
// - Available flag stays set while characters wait; a read pops one.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "usart_regs.vh"
module usart_rx_status (
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Register port
   input wire [8:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Serial pins
   input wire rx_data_pin_in,
   output reg rx_data_pin_out,
   output reg rx_data_pin_oe_n,
   input wire tx_clock_pin_in,
   output reg tx_clock_pin_out,
   output reg tx_clock_pin_oe_n,
   // Status to the core
   output wire rx_available_flag,
   output wire baud_tick
);
   localparam R_IDLE = 4'b0001;
   localparam R_START = 4'b0010;
   localparam R_DATA = 4'b0100;
   localparam R_STOP = 4'b1000;
   localparam T_IDLE = 2'b01;
   localparam T_SEND = 2'b10;

   function hit;
      input [8:0] a;
      input [8:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   reg [7:0] txsc_reg;
   reg port_en_reg, rx_nine_reg, single_rx_enable_reg, continuous_rx_enable_reg;
   reg [7:0] baud_divisor_reg;
   reg [7:0] baud_cnt_reg;
   reg rx_meta_reg, rx_s_reg, rx_prev_reg;
   reg ck_meta_reg, ck_s_reg, ck_prev_reg;
   reg [3:0] rx_state_reg;
   reg [4:0] rx_cnt_reg;
   reg [3:0] rx_bits_reg;
   reg [8:0] rx_shift_reg;
   reg push_reg, push_framing_error_reg;
   reg [8:0] push_data_reg;
   reg [9:0] fifo_mem [0:1];
   reg wr_ptr_reg, rd_ptr_reg;
   reg [1:0] count_reg;
   reg overrun_reg, framing_error_reg, ninth_reg;
   reg [1:0] tx_state_reg;
   reg [4:0] tx_cnt_reg;
   reg [3:0] tx_bits_reg;
   reg [11:0] tx_shift_reg;

   wire sync = txsc_reg[`TX_SYNC];
   wire master = txsc_reg[`TX_MASTER];
   wire pol = txsc_reg[`TX_POL];
   wire wr_txsc = reg_wr & hit(reg_addr, `ADDR_TXSC);
   wire wr_rxsc = reg_wr & hit(reg_addr, `ADDR_RXSC);
   wire wr_baud = reg_wr & hit(reg_addr, `ADDR_BAUD);
   wire wr_txd = reg_wr & hit(reg_addr, `ADDR_TXDATA);
   wire pop = reg_rd & hit(reg_addr, `ADDR_RXDATA) & (count_reg != 2'd0);
   wire rx_req = sync ? (continuous_rx_enable_reg | (single_rx_enable_reg & master)) : continuous_rx_enable_reg;
   wire rx_on = port_en_reg & ~overrun_reg & rx_req;
   wire tx_go = port_en_reg & txsc_reg[`TX_EN] & (~sync | master)
      & ~(sync & (continuous_rx_enable_reg | single_rx_enable_reg));
   wire [3:0] nbits = rx_nine_reg ? 4'd9 : 4'd8;
   wire [4:0] bit_len = sync ? `SYNC_BIT : `OVERSAMPLE;
   wire ck_eff = ck_s_reg ^ pol;
   wire ck_eff_prev = ck_prev_reg ^ pol;
   wire rx_idle = (rx_state_reg == R_IDLE);
   wire tx_empty = (tx_state_reg == T_IDLE);
   // async samples per bit 16, sync 4
   wire samp = sync ? (master ? (baud_tick & rx_cnt_reg == `SYNC_HALF - 5'd1)
      : (ck_eff_prev & ~ck_eff))
      : (baud_tick & rx_cnt_reg == `OVERSAMPLE - 5'd1);
   assign rx_available_flag = (count_reg != 2'd0);
   assign baud_tick = port_en_reg & (baud_cnt_reg == baud_divisor_reg);

   ////////////////////////////////////////////////////////////////////////
   // Control registers
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         txsc_reg <= `TXSC_RESET;
         port_en_reg <= 1'b0;
         rx_nine_reg <= 1'b0;
         single_rx_enable_reg <= 1'b0;
         continuous_rx_enable_reg <= 1'b0;
         baud_divisor_reg <= `BAUD_RESET;
      end else begin
         if (wr_txsc)
            txsc_reg <= reg_wdata;
         if (wr_rxsc) begin
            port_en_reg <= reg_wdata[`RX_PORT_EN];
            rx_nine_reg <= reg_wdata[`RX_NINE];
            single_rx_enable_reg <= reg_wdata[`RX_SINGLE];
            continuous_rx_enable_reg <= reg_wdata[`RX_CONT];
         end else if (push_reg & sync) begin
            single_rx_enable_reg <= 1'b0;
         end
         if (wr_baud)
            baud_divisor_reg <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Baud timer and pin synchronisers
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         baud_cnt_reg <= 8'h00;
         rx_meta_reg <= 1'b1;
         rx_s_reg <= 1'b1;
         rx_prev_reg <= 1'b1;
         ck_meta_reg <= 1'b0;
         ck_s_reg <= 1'b0;
         ck_prev_reg <= 1'b0;
      end else begin
         if (!port_en_reg || wr_baud)
            baud_cnt_reg <= 8'h00;
         else if (baud_cnt_reg == baud_divisor_reg)
            baud_cnt_reg <= 8'h00;
         else
            baud_cnt_reg <= baud_cnt_reg + 8'h01;
         rx_meta_reg <= rx_data_pin_in;
         rx_s_reg <= rx_meta_reg;
         rx_prev_reg <= rx_s_reg;
         ck_meta_reg <= tx_clock_pin_in;
         ck_s_reg <= ck_meta_reg;
         ck_prev_reg <= ck_s_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receiver
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_state_reg <= R_IDLE;
         rx_cnt_reg <= 5'h00;
         rx_bits_reg <= 4'h0;
         rx_shift_reg <= 9'h000;
         push_reg <= 1'b0;
         push_framing_error_reg <= 1'b0;
         push_data_reg <= 9'h000;
      end else begin
         push_reg <= 1'b0;
         if (baud_tick)
            rx_cnt_reg <= (rx_cnt_reg == bit_len - 5'd1) ? 5'h00
               : rx_cnt_reg + 5'd1;
         if (!rx_on) begin
            rx_state_reg <= R_IDLE;
            rx_cnt_reg <= 5'h00;
         end else begin
            case (rx_state_reg)
               R_IDLE: begin
                  rx_cnt_reg <= 5'h00;
                  rx_bits_reg <= 4'h0;
                  if (sync)
                     rx_state_reg <= R_DATA;
                  else if (rx_prev_reg & ~rx_s_reg)
                     rx_state_reg <= R_START;
               end
               R_START: begin
                  if (baud_tick && rx_cnt_reg == `HALF_BIT - 5'd1) begin
                     rx_cnt_reg <= 5'h00;
                     rx_state_reg <= rx_s_reg ? R_IDLE : R_DATA;
                  end
               end
               R_DATA: begin
                  if (samp) begin
                     rx_shift_reg <= {rx_s_reg, rx_shift_reg[8:1]};
                     rx_bits_reg <= rx_bits_reg + 4'd1;
                     if (rx_bits_reg == nbits - 4'd1) begin
                        rx_state_reg <= sync ? R_IDLE : R_STOP;
                        push_reg <= sync;
                        push_framing_error_reg <= 1'b0;
                        push_data_reg <= rx_nine_reg
                           ? {rx_s_reg, rx_shift_reg[8:1]}
                           : {1'b0, rx_s_reg, rx_shift_reg[8:2]};
                     end
                  end
               end
               R_STOP: begin
                  if (samp) begin
                     push_reg <= 1'b1;
                     push_framing_error_reg <= ~rx_s_reg;
                     rx_state_reg <= R_IDLE;
                  end
               end
               default: rx_state_reg <= R_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive buffer and error flags
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'd0;
         overrun_reg <= 1'b0;
         framing_error_reg <= 1'b0;
         ninth_reg <= 1'b0;
         fifo_mem[0] <= 10'h000;
         fifo_mem[1] <= 10'h000;
      end else if (!port_en_reg) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'd0;
         overrun_reg <= 1'b0;
         framing_error_reg <= 1'b0;
         ninth_reg <= 1'b0;
      end else begin
         if (push_reg && (count_reg != 2'd2 || pop)) begin
            fifo_mem[wr_ptr_reg] <= {push_framing_error_reg, push_data_reg};
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
            framing_error_reg <= fifo_mem[rd_ptr_reg][9];
            ninth_reg <= fifo_mem[rd_ptr_reg][8];
         end
         if (push_reg && (count_reg != 2'd2 || pop) && !pop)
            count_reg <= count_reg + 2'd1;
         else if (pop && !push_reg)
            count_reg <= count_reg - 2'd1;
         if (push_reg && count_reg == 2'd2 && !pop)
            overrun_reg <= 1'b1;
         else if ((wr_rxsc && !reg_wdata[`RX_CONT] && continuous_rx_enable_reg)
            || (pop && sync && !continuous_rx_enable_reg))
            overrun_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmitter; no holding register, so a write while busy is dropped
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_state_reg <= T_IDLE;
         tx_cnt_reg <= 5'h00;
         tx_bits_reg <= 4'h0;
         tx_shift_reg <= 12'hfff;
      end else if (!tx_go) begin
         tx_state_reg <= T_IDLE;
         tx_cnt_reg <= 5'h00;
         tx_shift_reg <= 12'hfff;
      end else begin
         case (tx_state_reg)
            T_IDLE: begin
               tx_cnt_reg <= 5'h00;
               if (wr_txd) begin
                  tx_state_reg <= T_SEND;
                  tx_shift_reg <= sync
                     ? {3'b111, txsc_reg[`TX_BIT9] | ~txsc_reg[`TX_NINE],
                        reg_wdata}
                     : {2'b11, txsc_reg[`TX_BIT9] | ~txsc_reg[`TX_NINE],
                        reg_wdata, 1'b0};
                  tx_bits_reg <= sync
                     ? (txsc_reg[`TX_NINE] ? 4'd9 : 4'd8)
                     : 4'd10 + {3'b000, txsc_reg[`TX_NINE]}
                        + {3'b000, ~txsc_reg[`TX_STOP1]};
               end
            end
            T_SEND: begin
               if (baud_tick) begin
                  if (tx_cnt_reg == bit_len - 5'd1) begin
                     tx_cnt_reg <= 5'h00;
                     tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
                     tx_bits_reg <= tx_bits_reg - 4'd1;
                     if (tx_bits_reg == 4'd1)
                        tx_state_reg <= T_IDLE;
                  end else begin
                     tx_cnt_reg <= tx_cnt_reg + 5'd1;
                  end
               end
            end
            default: tx_state_reg <= T_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive and register read-back
   wire ck_level = ((rx_state_reg == R_DATA) & master & sync
      & (rx_cnt_reg < `SYNC_HALF))
      | (~tx_empty & sync & (tx_cnt_reg < `SYNC_HALF));
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_data_pin_out <= 1'b1;
         rx_data_pin_oe_n <= 1'b1;
         tx_clock_pin_out <= 1'b1;
         tx_clock_pin_oe_n <= 1'b1;
         reg_rdata <= 8'h00;
      end else begin
         // pins belong to port when enabled
         tx_clock_pin_oe_n <= ~(port_en_reg & (~sync | master));
         tx_clock_pin_out <= sync ? (ck_level ^ pol)
            : (tx_shift_reg[0] ^ pol);
         rx_data_pin_oe_n <= ~(port_en_reg & sync & ~tx_empty);
         rx_data_pin_out <= tx_shift_reg[0];
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            if (hit(reg_addr, `ADDR_TXSC))
               reg_rdata <= {txsc_reg[7:2], tx_empty, txsc_reg[0]};
            else if (hit(reg_addr, `ADDR_RXSC))
               reg_rdata <= {port_en_reg, rx_nine_reg, single_rx_enable_reg, continuous_rx_enable_reg,
                  rx_idle, framing_error_reg, overrun_reg, ninth_reg};
            else if (hit(reg_addr, `ADDR_BAUD))
               reg_rdata <= baud_divisor_reg;
            else if (pop)
               reg_rdata <= fifo_mem[rd_ptr_reg][7:0];
         end
      end
   end
endmodule // usart_rx_status

// *** usart_rx_status_monitor.sv ***
// Concurrent checks on the serial status block's ports
`timescale 1ns/1ns
`include "usart_regs.vh"
module usart_rx_status_monitor (
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Register port
   input wire [8:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Serial pins
   input wire rx_data_pin_in,
   input wire rx_data_pin_out,
   input wire rx_data_pin_oe_n,
   input wire tx_clock_pin_in,
   input wire tx_clock_pin_out,
   input wire tx_clock_pin_oe_n,
   // Status
   input wire rx_available_flag,
   input wire baud_tick
);
////////////////////////////////////////////////////////////////////////////
reg [7:0] div_reg;
reg [7:0] cnt_reg;
reg [7:0] txsc_reg;
reg pen_reg;
wire div_wr = reg_wr && reg_addr == `ADDR_BAUD;
wire pop = reg_rd && reg_addr == `ADDR_RXDATA;
wire asy = !txsc_reg[`TX_SYNC];
wire quiet = asy && !txsc_reg[`TX_EN];
// Shadow timer; restarts wherever the real one must
always @(posedge core_clk or posedge sys_rst) begin
   if (sys_rst) begin
      div_reg <= 8'h00;
      cnt_reg <= 8'h00;
      txsc_reg <= 8'h00;
      pen_reg <= 1'b0;
   end else begin
      if (div_wr) begin
         div_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `ADDR_TXSC) begin
         txsc_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `ADDR_RXSC) begin
         pen_reg <= reg_wdata[`RX_PORT_EN];
      end
      if (!pen_reg || baud_tick || div_wr) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
end
////////////////////////////////////////////////////////////////////////////
default clocking mon_cb @(posedge core_clk);
endclocking
default disable iff (sys_rst);
tick_spacing_a:
assert property (baud_tick |-> pen_reg && cnt_reg == div_reg)
   else $error("baud tick off its period");
tick_due_a:
assert property (pen_reg && cnt_reg == div_reg |-> baud_tick)
   else $error("baud tick missing");
baud_readback_a:
assert property (reg_rd && reg_addr == `ADDR_BAUD
   |=> reg_rdata == $past(div_reg))
   else $error("divisor readback wrong");
avail_pop_a:
assert property ($fell(rx_available_flag) |-> $past(pop) || !pen_reg)
   else $error("available flag dropped without read");
avail_enabled_a:
assert property (rx_available_flag |-> pen_reg || $past(pen_reg))
   else $error("data available with port off");
pins_released_a:
assert property (!pen_reg && !$past(pen_reg)
   |-> tx_clock_pin_oe_n && rx_data_pin_oe_n)
   else $error("pin driven with port off");
data_pin_input_a:
assert property (asy && $past(asy) |-> rx_data_pin_oe_n)
   else $error("data pin driven in async mode");
tx_idle_a:
assert property (pen_reg && $past(pen_reg) && quiet && $past(quiet, 2)
   |-> tx_clock_pin_out == !txsc_reg[`TX_POL])
   else $error("send line not idle");
endmodule // usart_rx_status_monitor

bind usart_rx_status usart_rx_status_monitor usart_rx_status_monitor_inst (
   .core_clk(core_clk),
   .sys_rst(sys_rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .rx_data_pin_in(rx_data_pin_in),
   .rx_data_pin_out(rx_data_pin_out),
   .rx_data_pin_oe_n(rx_data_pin_oe_n),
   .tx_clock_pin_in(tx_clock_pin_in),
   .tx_clock_pin_out(tx_clock_pin_out),
   .tx_clock_pin_oe_n(tx_clock_pin_oe_n),
   .rx_available_flag(rx_available_flag),
   .baud_tick(baud_tick)
);

// *** serial_peer_model.sv ***
// Far-end async serial device for the bench
`timescale 1ns/1ns
module serial_peer_model #(
   parameter BIT_NS = 3200
) (
   // Line from the block
   input wire line_in,
   // Line to the block
   output reg line_out
);
initial line_out = 1'b1;
// Start, LSB first, one stop of chosen level, then idle high
task send(input [8:0] d, input integer nb, input stop);
   integer k;
   begin
      line_out = 1'b0;
      #(BIT_NS);
      for (k = 0; k < nb; k = k + 1) begin
         line_out = d[k];
         #(BIT_NS);
      end
      line_out = stop;
      #(BIT_NS);
      line_out = 1'b1;
      #(BIT_NS);
   end
endtask
// Samples at bit centres; returns at the first stop centre
task recv(input integer nb, output [8:0] d, output stop);
   integer k;
   begin
      d = 9'h000;
      @(negedge line_in);
      #(BIT_NS / 2);
      for (k = 0; k < nb; k = k + 1) begin
         #(BIT_NS);
         d[k] = line_in;
      end
      #(BIT_NS);
      stop = line_in;
   end
endtask
// Short low pulse that must not pass as a start bit
task glitch;
   begin
      line_out = 1'b0;
      #(BIT_NS / 4);
      line_out = 1'b1;
      #(BIT_NS * 2);
   end
endtask
endmodule // serial_peer_model

// *** usart_rx_status_tb.sv ***
// Self-checking bench for the serial status block
`timescale 1ns/1ns
`include "usart_regs.vh"
module usart_rx_status_tb;
localparam [7:0] DIV = 8'h01;
localparam integer BIT_NS = 1600 * (DIV + 1);
reg core_clk = 1'b0;
reg sys_rst = 1'b1;
reg [8:0] reg_addr = 9'h000;
reg [7:0] reg_wdata = 8'h00;
reg reg_wr = 1'b0;
reg reg_rd = 1'b0;
reg ext_clk = 1'b0;
reg [8:0] got = 9'h000;
reg stop_seen = 1'b0;
integer n_errors = 0;
integer samples_checked = 0;
integer cycles = 0;
wire [7:0] reg_rdata;
wire rx_data_pin_out, rx_data_pin_oe_n, tx_clock_pin_out, tx_clock_pin_oe_n;
wire rx_available_flag, baud_tick, peer_out;
// Released clock pin idles high
wire peer_in = tx_clock_pin_oe_n ? 1'b1 : tx_clock_pin_out;
wire rx_data_pin_in = rx_data_pin_oe_n ? peer_out : rx_data_pin_out;
wire tx_clock_pin_in = tx_clock_pin_oe_n ? ext_clk : tx_clock_pin_out;
usart_rx_status usart_rx_status_inst (
   .core_clk(core_clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .rx_data_pin_in(rx_data_pin_in), .rx_data_pin_out(rx_data_pin_out),
   .rx_data_pin_oe_n(rx_data_pin_oe_n), .tx_clock_pin_in(tx_clock_pin_in),
   .tx_clock_pin_out(tx_clock_pin_out),
   .tx_clock_pin_oe_n(tx_clock_pin_oe_n),
   .rx_available_flag(rx_available_flag), .baud_tick(baud_tick)
);
serial_peer_model #(.BIT_NS(BIT_NS)) serial_peer_model_inst (
   .line_in(peer_in), .line_out(peer_out)
);
////////////////////////////////////////////////////////////////////////////
task chk(input [8:0] seen, input [8:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   end
endtask
task wr(input [8:0] a, input [7:0] d);
   begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   end
endtask
task rd(input [8:0] a, input [7:0] exp);
   begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      chk(9'(reg_rdata), 9'(exp));
   end
endtask
task conclude;
   begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
endtask
////////////////////////////////////////////////////////////////////////////
task t_reset;
   begin
      rd(`ADDR_TXSC, `TXSC_RESET); // empty at reset
      rd(`ADDR_BAUD, `BAUD_RESET); // divisor reset
      rd(9'h100, 8'h00);
      rd(`ADDR_RXDATA, 8'h00); // empty pop
   end
endtask
task t_baud;
   reg [8:0] n;
   begin
      wr(`ADDR_RXSC, 8'h80);
      rd(`ADDR_RXSC, 8'h88); // idle before rate change
      wr(`ADDR_BAUD, DIV);
      rd(`ADDR_BAUD, DIV); // divisor readback
      chk(9'(tx_clock_pin_oe_n), 9'h000); // pin owned
      @(posedge core_clk);
      while (baud_tick !== 1'b1) begin
         @(posedge core_clk);
      end
      @(posedge core_clk);
      n = 9'h001;
      while (baud_tick !== 1'b1) begin
         @(posedge core_clk);
         n = n + 9'h001;
      end
      chk(n, 9'(DIV) + 9'h001); // tick period
   end
endtask
task t_rx9;
   begin
      wr(`ADDR_RXSC, 8'hd0);
      fork
         serial_peer_model_inst.send(9'h1a5, 9, 1'b1);
         begin
            #(BIT_NS * 3);
            rd(`ADDR_RXSC, 8'hd0); // busy mid frame
         end
      join
      chk(9'(rx_available_flag), 9'h001); // data waiting
      rd(`ADDR_RXDATA, 8'ha5); // nine bit frame
      chk(9'(rx_available_flag), 9'h000); // popped empty
      rd(`ADDR_RXSC, 8'hd9); // ninth bit shown
      serial_peer_model_inst.send(9'h05a, 9, 1'b0);
      rd(`ADDR_RXDATA, 8'h5a); // nine bit frame
      rd(`ADDR_RXSC, 8'hdc); // framing flag set
   end
endtask
task t_overrun;
   begin
      wr(`ADDR_RXSC, 8'h00);
      wr(`ADDR_RXSC, 8'h90);
      serial_peer_model_inst.send(9'h011, 8, 1'b1);
      serial_peer_model_inst.send(9'h022, 8, 1'b1);
      serial_peer_model_inst.send(9'h033, 8, 1'b1);
      rd(`ADDR_RXSC, 8'h9a); // overrun on third
      rd(`ADDR_RXDATA, 8'h11); // oldest kept
      rd(`ADDR_RXDATA, 8'h22); // second kept
      serial_peer_model_inst.send(9'h044, 8, 1'b1);
      chk(9'(rx_available_flag), 9'h000); // receiver blocked
      wr(`ADDR_RXSC, 8'h80);
      rd(`ADDR_RXSC, 8'h88); // cleared with enable
   end
endtask
task t_reject;
   begin
      wr(`ADDR_RXSC, 8'h00);
      repeat (2) @(posedge core_clk);
      chk(9'({tx_clock_pin_oe_n, rx_data_pin_oe_n}), 9'h003); // freed
      wr(`ADDR_RXSC, 8'ha0);
      serial_peer_model_inst.send(9'h055, 8, 1'b1);
      chk(9'(rx_available_flag), 9'h000); // single ignored async
      wr(`ADDR_RXSC, 8'h90);
      serial_peer_model_inst.glitch;
      chk(9'(rx_available_flag), 9'h000); // false start dropped
      serial_peer_model_inst.send(9'h066, 8, 1'b1);
      rd(`ADDR_RXDATA, 8'h66); // centre sampling
   end
endtask
task t_tx;
   integer i;
   reg [7:0] cfg;
   begin
      for (i = 0; i < 2; i = i + 1) begin
         cfg = (i != 0) ? 8'h65 : 8'h61;
         wr(`ADDR_TXSC, cfg);
         wr(`ADDR_TXDATA, 8'ha6);
         fork
            serial_peer_model_inst.recv(9, got, stop_seen);
            rd(`ADDR_TXSC, cfg); // busy reads zero
         join
         chk(got, 9'h1a6); // ninth bit sent
         chk(9'(stop_seen), 9'h001); // stop level
         #(BIT_NS);
         rd(`ADDR_TXSC, cfg | ((i != 0) ? 8'h02 : 8'h00)); // stops
         #(BIT_NS);
      end
   end
endtask
task t_sync;
   integer k;
   reg [8:0] d;
   begin
      wr(`ADDR_TXSC, 8'hb0);
      wr(`ADDR_TXDATA, 8'h3c);
      rd(`ADDR_TXSC, 8'hb2); // receive blocks send
      // Let the receive clock die out before sending
      wr(`ADDR_RXSC, 8'h80);
      repeat (4) @(posedge core_clk);
      wr(`ADDR_TXDATA, 8'h3c);
      d = 9'h000;
      for (k = 0; k < 8; k = k + 1) begin
         @(negedge tx_clock_pin_out);
         d[k] = rx_data_pin_out;
      end
      chk(9'(rx_data_pin_oe_n), 9'h000); // data pin driven
      chk(d, 9'h03c); // sync send allowed
   end
endtask
////////////////////////////////////////////////////////////////////////////
always #50 core_clk = ~core_clk;
// Ceiling well above the few thousand cycles the run needs
always @(posedge core_clk) begin
   cycles = cycles + 1;
   if (cycles == 20000) begin
      n_errors = n_errors + 1;
      conclude;
   end
end
initial begin
   repeat (6) @(posedge core_clk);
   sys_rst <= 1'b0;
   t_reset;
   t_baud;
   t_rx9;
   t_overrun;
   t_reject;
   t_tx;
   t_sync;
   conclude;
end
endmodule // usart_rx_status_tb
